// ==== async_serial_txrx_core.sv ====
`timescale 1ns/1ps
// Overview of operation
// (R1) one baud generator fed from the bus clock times both transmitter and receiver
// (R2) transmit line idles high after reset; tx_invert flips every transmitted level
// (R3) setting transmitter_enable queues one idle preamble frame, then waits for data
// (R4) transmit frame is 10 bits in 8-bit mode, 11 in 9-bit mode
// (R5) free shifter loads waiting data on the bit clock and sets buffer empty
// (R6) nothing waiting after a stop bit: set transmit complete, idle high
// (R7) clearing transmitter_enable keeps the pin until data, idle and break are done
// (R8) sbk pulse queues a break; still set at break load queues another
// (R9) break lasts 10, 11, 13 or 14 bit times by long break and word size
// (R10) enable cleared then set again queues one idle character
// (R11) pin stays driven while enable is briefly low and shifter busy
// (R12) received frame: zero start, 8 or 9 bits LSB first, one stop; rx_invert first
// (R13) after stop bit, empty buffer takes character and sets buffer full
// (R14) buffer still full on completion: set overrun, drop new character
// (R15) buffer full flag clears by host access sequence, no write needed
// (R16) clear is status read with flag set, then data read
// (R17) receiver samples at sixteen slots per bit
// (R18) falling edge is a zero after three consecutive ones
// (R19) start accepted when two of slots 3, 5, 7 are zero
// (R20) each bit voted at slots 8, 9, 10; start bit forced zero
// (R21) any disagreeing sample sets noise at buffer transfer
// (R22) edge detector runs all frame and resyncs slot count on edges; code ignores edges at slots 4 to 10
// (R23) zero in stop position sets framing error with buffer full
// (R24) framing error on non-break preloads edge history with three ones
// (R25) while framing error set, completed characters are not transferred
// (R26) baud divider modulo value gives 16x tick; bit clock is tick over sixteen
module async_serial_txrx_core (
  // clock, reset, enable
  input  wire logic                      clock_i,
  input  wire logic                      rst_i,
  input  wire logic                      ce_i,
  // register port
  input  wire logic [serial_pkg::AW-1:0] addr_i,
  input  wire logic [serial_pkg::DW-1:0] wdata_i,
  input  wire logic                      wr_i,
  input  wire logic                      rd_i,
  output logic      [serial_pkg::DW-1:0] rdata_o,
  // serial link
  input  wire logic                      rx_i,
  output logic                           tx_o,
  output logic                           tx_oe_o
);
  serial_pkg::ctrl_t     ctrl;
  serial_pkg::rx_flags_t flags;
  serial_pkg::rx_state_t rx_state;

  logic       tick16;
  logic       bit_tick;
  logic [3:0] tx_phase;
  logic [7:0] tdr;
  logic       tdr8;
  logic       tx_buffer_empty_flag;
  logic       tc;
  logic       idle_q;
  logic       break_q;
  logic [13:0] tx_shift;
  logic       tx_fill;
  logic [3:0] tx_cnt;
  logic       tx_line;
  logic [3:0] frame_len;
  logic [3:0] brk_len;
  logic       tx_load;
  logic       data_go;
  logic       data_wr;
  logic       ctrl2_wr;
  logic       te_rise;
  logic       sbk_rise;

  // ----------------------------------------------------------
  // baud generation
  // ----------------------------------------------------------
  // (R1) shared generator
  baud_tick_gen u_baud (
    .clock_i   (clock_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .divisor_i (ctrl.baud),
    .tick_o    (tick16)
  );

  // (R26) bit clock from tick
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      tx_phase <= '0;
    end else if (tick16) begin
      tx_phase <= tx_phase + 1'b1;
    end
  end
  assign bit_tick = tick16 && (tx_phase == serial_pkg::PHASE_LAST);

  // ----------------------------------------------------------
  // control registers
  // ----------------------------------------------------------
  assign data_wr  = ce_i && wr_i && (addr_i == serial_pkg::A_DATA);
  assign ctrl2_wr = ce_i && wr_i && (addr_i == serial_pkg::A_CTRL2);
  assign te_rise  = ctrl2_wr && wdata_i[serial_pkg::B_TE] && !ctrl.te;
  assign sbk_rise = ctrl2_wr && wdata_i[serial_pkg::B_SBK] && !ctrl.send_break_control;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ctrl <= '0;
      ctrl.baud <= serial_pkg::BAUD_RST;
    end else if (ce_i && wr_i) begin
      case (addr_i)
        serial_pkg::A_BAUD_HI: ctrl.baud[12:8] <= wdata_i[4:0];
        serial_pkg::A_BAUD_LO: ctrl.baud[7:0] <= wdata_i;
        serial_pkg::A_CTRL1: ctrl.word9 <= wdata_i[serial_pkg::B_WORD9];
        serial_pkg::A_CTRL2: begin
          ctrl.te  <= wdata_i[serial_pkg::B_TE];
          ctrl.re  <= wdata_i[serial_pkg::B_RE];
          ctrl.send_break_control <= wdata_i[serial_pkg::B_SBK];
        end
        serial_pkg::A_STAT2: begin
          ctrl.rx_invert  <= wdata_i[serial_pkg::B_RX_INVERT];
          ctrl.long_break <= wdata_i[serial_pkg::B_LBRK];
        end
        serial_pkg::A_CTRL3: begin
          ctrl.t8        <= wdata_i[serial_pkg::B_T8];
          ctrl.tx_invert <= wdata_i[serial_pkg::B_TX_INVERT];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------
  // (R4) frame length by word size
  assign frame_len = ctrl.word9 ? serial_pkg::LEN9 : serial_pkg::LEN8;
  // (R9) break length table
  always_comb begin
    if (!ctrl.long_break) begin
      brk_len = frame_len;
    end else begin
      brk_len = ctrl.word9 ? serial_pkg::BRK14 : serial_pkg::LONG_BREAK_SELECT;
    end
  end
  assign tx_load = bit_tick && (tx_cnt <= 4'h1);
  assign data_go = tx_load && !idle_q && !break_q && !tx_buffer_empty_flag && ctrl.te;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      tx_shift <= '1;
      tx_fill  <= 1'b1;
      tx_cnt   <= '0;
      tx_line  <= 1'b1;
    end else if (tx_load) begin
      if (idle_q) begin
        tx_line  <= 1'b1;
        tx_shift <= '1;
        tx_fill  <= 1'b1;
        tx_cnt   <= frame_len;
      end else if (break_q) begin
        tx_line  <= 1'b0;
        tx_shift <= '0;
        tx_fill  <= 1'b0;
        tx_cnt   <= brk_len;
      end else if (data_go) begin
        // (R4) start bit out now, data and stop queued
        tx_line  <= 1'b0;
        tx_shift <= ctrl.word9 ? {5'h1f, tdr8, tdr} : {6'h3f, tdr};
        tx_fill  <= 1'b1;
        tx_cnt   <= frame_len;
      end else begin
        // (R6) idle at mark level
        tx_line <= 1'b1;
        tx_cnt  <= '0;
      end
    end else if (bit_tick && tx_cnt != '0) begin
      tx_line  <= tx_shift[0];
      tx_shift <= {tx_fill, tx_shift[13:1]};
      tx_cnt   <= tx_cnt - 1'b1;
    end
  end

  // a write landing on the load cycle refills the buffer, so the write wins here
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      tdr  <= '0;
      tdr8 <= 1'b0;
      tx_buffer_empty_flag <= 1'b1;
    end else if (ce_i) begin
      // (R5) buffer empty on load
      if (data_go) begin
        tx_buffer_empty_flag <= 1'b1;
      end
      if (data_wr) begin
        tdr  <= wdata_i;
        tdr8 <= ctrl.t8;
        tx_buffer_empty_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      idle_q  <= 1'b0;
      break_q <= 1'b0;
      tc      <= 1'b1;
    end else if (ce_i) begin
      if (tx_load && idle_q) begin
        idle_q <= 1'b0;
      end
      // (R3) (R10) enable edge queues idle
      if (te_rise) begin
        idle_q <= 1'b1;
      end
      if (tx_load && !idle_q && break_q) begin
        break_q <= ctrl.send_break_control;
      end
      // (R8) host pulse queues break
      if (sbk_rise) begin
        break_q <= 1'b1;
      end
      if (data_wr || te_rise || sbk_rise) begin
        tc <= 1'b0;
      end
      // (R6) complete when nothing follows
      if (tx_load && !idle_q && !break_q && !data_go && tx_cnt != '0) begin
        tc <= 1'b1;
      end
    end
  end

  // (R7) (R11) pin held while work remains
  assign tx_oe_o = ctrl.te || (tx_cnt != '0) || idle_q || break_q;
  // (R2) polarity control
  assign tx_o = tx_line ^ ctrl.tx_invert;

  // ----------------------------------------------------------
  // receiver
  // ----------------------------------------------------------
  logic       rxd;
  logic       samp_en;
  logic [2:0] hist;
  logic       fall;
  logic [4:0] rt;
  logic [3:0] bitnum;
  logic [3:0] stop_idx;
  logic [1:0] samp;
  logic [8:0] rx_shift;
  logic       noise_acc;
  logic       all_zero;
  logic       maj;
  logic       dis;
  logic       capture;
  logic       rx_done;
  logic       noise_final;
  logic [7:0] rbuf;
  logic       r8;
  logic       armed;
  logic       rd_stat;
  logic       rd_data;

  // (R12) inversion ahead of framing
  assign rxd      = rx_i ^ ctrl.rx_invert;
  assign samp_en  = tick16 && ctrl.re;
  // (R18) three ones then zero
  assign fall     = (hist == serial_pkg::HIST_ONES) && !rxd;
  assign stop_idx = ctrl.word9 ? serial_pkg::STOP9 : serial_pkg::STOP8;
  assign capture  = (bitnum == '0 && (rt == serial_pkg::SLOT_V1 || rt == serial_pkg::SLOT_V2))
                    || rt == serial_pkg::SLOT_M1 || rt == serial_pkg::SLOT_M2;
  assign rx_done  = samp_en && rx_state == serial_pkg::RX_FRAME && rt == serial_pkg::SLOT_M3
                    && bitnum == stop_idx;
  assign noise_final = noise_acc | dis;

  vote3 u_vote (
    .samples_i  ({samp, rxd}),
    .majority_o (maj),
    .disagree_o (dis)
  );

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rx_state  <= serial_pkg::RX_HUNT;
      hist      <= '0;
      rt        <= serial_pkg::SLOT_FIRST;
      bitnum    <= '0;
      samp      <= '0;
      rx_shift  <= '0;
      noise_acc <= 1'b0;
      all_zero  <= 1'b1;
    end else if (ce_i && !ctrl.re) begin
      rx_state <= serial_pkg::RX_HUNT;
    end else if (samp_en) begin
      hist <= {hist[1:0], rxd};
      case (rx_state)
        serial_pkg::RX_HUNT: begin
          if (fall) begin
            rx_state  <= serial_pkg::RX_FRAME;
            rt        <= serial_pkg::SLOT_EDGE2;
            bitnum    <= '0;
            noise_acc <= 1'b0;
            all_zero  <= 1'b1;
          end
        end
        serial_pkg::RX_FRAME: begin
          if (capture) begin
            samp <= {samp[0], rxd};
          end
          // (R22) resync on edges away from the vote window
          if (fall && (rt >= serial_pkg::SLOT_LATE || rt <= serial_pkg::SLOT_V1)) begin
            rt <= serial_pkg::SLOT_EDGE2;
            if (rt >= serial_pkg::SLOT_LATE) begin
              bitnum <= bitnum + 1'b1;
            end
          // (R17) sixteen slots per bit
          end else if (rt == serial_pkg::SLOT_LAST) begin
            rt     <= serial_pkg::SLOT_FIRST;
            bitnum <= bitnum + 1'b1;
          end else begin
            rt <= rt + 1'b1;
          end
          // (R19) start verification
          if (bitnum == '0 && rt == serial_pkg::SLOT_V3) begin
            if (maj) begin
              rx_state <= serial_pkg::RX_HUNT;
            end else begin
              noise_acc <= noise_acc | dis;
            end
          end
          if (rt == serial_pkg::SLOT_M3) begin
            if (bitnum == '0) begin
              // (R20) start forced zero; any one is noise
              noise_acc <= noise_acc | (|{samp, rxd});
            end else if (bitnum != stop_idx) begin
              // (R12) LSB first
              rx_shift  <= {maj, rx_shift[8:1]};
              noise_acc <= noise_acc | dis;
              all_zero  <= all_zero & !maj;
            end else begin
              rx_state <= serial_pkg::RX_HUNT;
              // (R24) fast restart after non-break framing error
              if (!maj && !all_zero) begin
                hist <= serial_pkg::HIST_ONES;
              end
            end
          end
        end
        default: rx_state <= serial_pkg::RX_HUNT;
      endcase
    end
  end

  // ----------------------------------------------------------
  // receive buffer and status
  // ----------------------------------------------------------
  assign rd_stat = ce_i && rd_i && (addr_i == serial_pkg::A_STAT1);
  assign rd_data = ce_i && rd_i && (addr_i == serial_pkg::A_DATA);

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      flags <= '0;
      rbuf  <= '0;
      r8    <= 1'b0;
      armed <= 1'b0;
    end else if (ce_i) begin
      // (R15) (R16) status read arms, data read clears
      if (rd_stat) begin
        armed <= |flags;
      end else if (rd_data) begin
        armed <= 1'b0;
      end
      if (rd_data && armed) begin
        flags <= '0;
      end
      // (R25) held off while framing error stands
      if (rx_done && !flags.fe) begin
        if (flags.rx_buffer_full_flag) begin
          // (R14) new character lost
          flags.ovr <= 1'b1;
        end else begin
          // (R13) (R21) (R23) transfer with error flags
          rbuf       <= ctrl.word9 ? rx_shift[7:0] : rx_shift[8:1];
          r8         <= ctrl.word9 & rx_shift[8];
          flags.rx_buffer_full_flag <= 1'b1;
          flags.nf   <= noise_final;
          flags.fe   <= !maj;
        end
      end
    end
  end

  // ----------------------------------------------------------
  // register read port
  // ----------------------------------------------------------
  logic [7:0] rd_val;
  always_comb begin
    rd_val = '0;
    case (addr_i)
      serial_pkg::A_BAUD_HI: rd_val[4:0] = ctrl.baud[12:8];
      serial_pkg::A_BAUD_LO: rd_val = ctrl.baud[7:0];
      serial_pkg::A_CTRL1: rd_val[serial_pkg::B_WORD9] = ctrl.word9;
      serial_pkg::A_CTRL2: begin
        rd_val[serial_pkg::B_TE]  = ctrl.te;
        rd_val[serial_pkg::B_RE]  = ctrl.re;
        rd_val[serial_pkg::B_SBK] = ctrl.send_break_control;
      end
      serial_pkg::A_STAT1: begin
        rd_val[serial_pkg::B_TX_BUFFER_EMPTY_FLAG] = tx_buffer_empty_flag;
        rd_val[serial_pkg::B_TC]   = tc;
        rd_val[serial_pkg::B_RX_BUFFER_FULL_FLAG] = flags.rx_buffer_full_flag;
        rd_val[serial_pkg::B_OVR]  = flags.ovr;
        rd_val[serial_pkg::B_NF]   = flags.nf;
        rd_val[serial_pkg::B_FE]   = flags.fe;
      end
      serial_pkg::A_STAT2: begin
        rd_val[serial_pkg::B_RX_INVERT] = ctrl.rx_invert;
        rd_val[serial_pkg::B_LBRK]  = ctrl.long_break;
      end
      serial_pkg::A_CTRL3: begin
        rd_val[serial_pkg::B_R8]    = r8;
        rd_val[serial_pkg::B_T8]    = ctrl.t8;
        rd_val[serial_pkg::B_TX_INVERT] = ctrl.tx_invert;
      end
      serial_pkg::A_DATA: rd_val = rbuf;
      default: rd_val = '0;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else if (ce_i && rd_i) begin
      rdata_o <= rd_val;
    end
  end

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  a_tx_idle_level: assert property ((tx_cnt == '0) |-> (tx_o != ctrl.tx_invert)) // (R2)
    else $error("idle transmit level wrong");
  a_preamble_queue: assert property (te_rise |=> idle_q) // (R3)
    else $error("preamble not queued");
  a_tx_buffer_empty_flag_on_load: assert property ((data_go && !data_wr) |=> tx_buffer_empty_flag && tx_cnt == $past(frame_len) && !tx_line) // (R5)
    else $error("data load wrong");
  a_tc_on_finish: assert property ((tx_load && !idle_q && !break_q && !data_go && tx_cnt != '0) |=> tc && tx_cnt == '0) // (R6)
    else $error("transmit complete missed");
  a_pin_held: assert property ((tx_cnt != '0 || idle_q) |-> tx_oe_o) // (R7)
    else $error("pin released early");
  a_break_len: assert property ((tx_load && !idle_q && break_q) |=> tx_cnt == $past(brk_len) && !tx_line) // (R9)
    else $error("break length wrong");
  a_edge_start: assert property ((samp_en && rx_state == serial_pkg::RX_HUNT && fall)
    |=> rx_state == serial_pkg::RX_FRAME && rt == serial_pkg::SLOT_EDGE2) // (R18)
    else $error("edge not taken");
  a_overrun_drop: assert property ((rx_done && flags.rx_buffer_full_flag && !flags.fe) |=> flags.ovr && $stable(rbuf)) // (R14)
    else $error("overrun not flagged");
  a_fe_blocks: assert property ((rx_done && flags.fe) |=> $stable(rbuf)) // (R25)
    else $error("transfer under framing error");
  a_rx_buffer_full_flag_clear: assert property ((rd_data && armed && !rx_done) |=> !flags.rx_buffer_full_flag) // (R16)
    else $error("buffer full not cleared");

  c_break_sent: cover property (tx_load && !idle_q && break_q);
  c_overrun: cover property (rx_done && flags.rx_buffer_full_flag);
  c_noisy_char: cover property (rx_done && noise_final && !flags.rx_buffer_full_flag && !flags.fe);
endmodule : async_serial_txrx_core

// ==== serial_pkg.sv ====
package serial_pkg;
  localparam int AW     = 3;
  localparam int DW     = 8;
  localparam int BAUD_W = 13;

  // ----------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------
  localparam logic [AW-1:0] A_BAUD_HI = 3'h0;
  localparam logic [AW-1:0] A_BAUD_LO = 3'h1;
  localparam logic [AW-1:0] A_CTRL1   = 3'h2;
  localparam logic [AW-1:0] A_CTRL2   = 3'h3;
  localparam logic [AW-1:0] A_STAT1   = 3'h4;
  localparam logic [AW-1:0] A_STAT2   = 3'h5;
  localparam logic [AW-1:0] A_CTRL3   = 3'h6;
  localparam logic [AW-1:0] A_DATA    = 3'h7;

  // ----------------------------------------------------------
  // field positions
  // ----------------------------------------------------------
  localparam int B_WORD9 = 4;
  localparam int B_TE    = 3;
  localparam int B_RE    = 2;
  localparam int B_SBK   = 0;
  localparam int B_TX_BUFFER_EMPTY_FLAG  = 7;
  localparam int B_TC    = 6;
  localparam int B_RX_BUFFER_FULL_FLAG  = 5;
  localparam int B_OVR   = 3;
  localparam int B_NF    = 2;
  localparam int B_FE    = 1;
  localparam int B_RX_INVERT = 4;
  localparam int B_LBRK  = 2;
  localparam int B_R8    = 7;
  localparam int B_T8    = 6;
  localparam int B_TX_INVERT = 4;

  // ----------------------------------------------------------
  // reset values, frame lengths, sample slots
  // ----------------------------------------------------------
  localparam logic [BAUD_W-1:0] BAUD_RST = 13'h0004;
  localparam logic [3:0] LEN8       = 4'ha;
  localparam logic [3:0] LEN9       = 4'hb;
  localparam logic [3:0] LONG_BREAK_SELECT      = 4'hd;
  localparam logic [3:0] BRK14      = 4'he;
  localparam logic [3:0] STOP8      = 4'h9;
  localparam logic [3:0] STOP9      = 4'ha;
  localparam logic [3:0] PHASE_LAST = 4'hf;
  localparam logic [2:0] HIST_ONES  = 3'h7;
  localparam logic [4:0] SLOT_FIRST = 5'h01;
  localparam logic [4:0] SLOT_EDGE2 = 5'h02;
  localparam logic [4:0] SLOT_V1    = 5'h03;
  localparam logic [4:0] SLOT_V2    = 5'h05;
  localparam logic [4:0] SLOT_V3    = 5'h07;
  localparam logic [4:0] SLOT_M1    = 5'h08;
  localparam logic [4:0] SLOT_M2    = 5'h09;
  localparam logic [4:0] SLOT_M3    = 5'h0a;
  localparam logic [4:0] SLOT_LATE  = 5'h0b;
  localparam logic [4:0] SLOT_LAST  = 5'h10;

  typedef struct packed {
    logic [BAUD_W-1:0] baud;
    logic              word9;
    logic              te;
    logic              re;
    logic              send_break_control;
    logic              tx_invert;
    logic              rx_invert;
    logic              long_break;
    logic              t8;
  } ctrl_t;

  typedef struct packed {
    logic rx_buffer_full_flag;
    logic ovr;
    logic nf;
    logic fe;
  } rx_flags_t;

  typedef enum logic {RX_HUNT, RX_FRAME} rx_state_t;
endpackage : serial_pkg

// ==== baud_tick_gen.sv ====
`timescale 1ns/1ps
module baud_tick_gen (
  // clock, reset, enable
  input  wire logic                          clock_i,
  input  wire logic                          rst_i,
  input  wire logic                          ce_i,
  // divisor and tick
  input  wire logic [serial_pkg::BAUD_W-1:0] divisor_i,
  output logic                               tick_o
);
  logic [serial_pkg::BAUD_W-1:0] count;
  logic                          wrap;

  assign wrap = (count == divisor_i - 1'b1);
  // combinational so a frozen clock enable never repeats a tick
  assign tick_o = ce_i && (divisor_i != '0) && wrap;

  // (R26) modulo divider
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      count <= '0;
    end else if (ce_i) begin
      if (divisor_i == '0 || wrap || count >= divisor_i) begin
        count <= '0;
      end else begin
        count <= count + 1'b1;
      end
    end
  end

  a_tick_spacing: assert property (@(posedge clock_i) disable iff (rst_i) // (R26)
    (tick_o && divisor_i > 13'h0001) |=> !tick_o) else $error("sample tick repeated");
endmodule : baud_tick_gen

// ==== vote3.sv ====
`timescale 1ns/1ps
module vote3 (
  // three samples in
  input  wire logic [2:0] samples_i,
  // resolved level
  output logic            majority_o,
  output logic            disagree_o
);
  // (R20) two of three
  assign majority_o = (samples_i[0] & samples_i[1]) | (samples_i[0] & samples_i[2]) | (samples_i[1] & samples_i[2]);
  // (R21) a sample off the majority
  assign disagree_o = (|samples_i) & ~(&samples_i);
endmodule : vote3

// ==== serial_peer.sv ====
`timescale 1ns/1ps
module serial_peer #(
  parameter int BITC = 32
) (
  // clock
  input  wire logic clock_i,
  // serial lines
  input  wire logic line_i,
  output logic      line_o
);
  logic [7:0] got;

  initial line_o = 1'b1;

  // ------------------------------
  // receive side
  // ------------------------------
  // sample mid bit, lsb first
  always begin
    @(negedge line_i);
    repeat (BITC / 2) @(posedge clock_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BITC) @(posedge clock_i);
      got[i] = line_i;
    end
    repeat (BITC) @(posedge clock_i);
  end

  // noisy names one bit that gets a short opposite pulse near its middle
  task automatic send(input logic [7:0] v, input logic stop, input int noisy = -1);
    logic [9:0] f;
    f = {stop, v, 1'b0};
    @(posedge clock_i);
    for (int i = 0; i < 10; i++) begin
      line_o <= f[i];
      if (i == noisy) begin
        repeat (BITC / 2) @(posedge clock_i);
        line_o <= !f[i];
        repeat (2) @(posedge clock_i);
        line_o <= f[i];
        repeat (BITC / 2 - 2) @(posedge clock_i);
      end else begin
        repeat (BITC) @(posedge clock_i);
      end
    end
    // one idle bit so the next start is a clean falling edge
    line_o <= 1'b1;
    repeat (BITC) @(posedge clock_i);
  endtask : send
endmodule : serial_peer

// ==== async_serial_txrx_core_tb.sv ====
`timescale 1ns/1ps
module async_serial_txrx_core_tb;
  localparam int BITC = 32;
  logic                      clock_i, rst_i, ce_i, wr_i, rd_i, rx_i, tx_o, tx_oe_o;
  logic [serial_pkg::AW-1:0] addr_i;
  logic [serial_pkg::DW-1:0] wdata_i, rdata_o, d;
  int                        bad_count, checked, n;
  int                        blen[4] = '{10, 11, 13, 14};
  time                       t0;

  async_serial_txrx_core i_async_serial_txrx_core (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .rx_i(rx_i), .tx_o(tx_o), .tx_oe_o(tx_oe_o));
  // a released transmit pin floats to its pull-up level
  serial_peer #(.BITC(BITC)) i_serial_peer (.clock_i(clock_i), .line_i(tx_oe_o ? tx_o : 1'b1), .line_o(rx_i));

  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  // ------------------------------
  // helpers
  // ------------------------------
  task automatic print_verdict;
    $display("checked %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // bounded wait step; #1 lets the edge's updates land first
  task automatic step(inout int k);
    @(posedge clock_i);
    #1;
    k++;
    if (k > 4000) begin
      bad_count++;
      print_verdict();
    end
  endtask : step

  task automatic wr(input logic [serial_pkg::AW-1:0] a, input logic [7:0] v);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [serial_pkg::AW-1:0] a);
    @(posedge clock_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask : rd

  // ------------------------------
  // sequence
  // ------------------------------
  initial begin
    {rst_i, ce_i, wr_i, rd_i, addr_i, wdata_i} = {2'b11, 2'b00, 3'h0, 8'h00};
    {bad_count, checked, t0} = '0;
    repeat (12) @(posedge clock_i);
    rst_i <= 1'b0;
    chk("idle level", 8'h01, {7'h0, tx_o});
    chk("pin drive", 8'h00, {7'h0, tx_oe_o});
    rd(serial_pkg::A_STAT1);
    chk("status reset", 8'hc0, d);
    wr(serial_pkg::A_BAUD_HI, 8'h00);
    wr(serial_pkg::A_BAUD_LO, 8'h02);
    wr(serial_pkg::A_CTRL2, 8'h0c);
    wr(serial_pkg::A_DATA, 8'ha5);
    n = 0;
    while (tx_o !== 1'b0) step(n);
    t0 = $time - 1;
    rd(serial_pkg::A_STAT1);
    chk("empty after load", 8'h80, d & 8'h80);
    wr(serial_pkg::A_CTRL2, 8'h04);
    repeat (BITC) @(posedge clock_i);
    chk("pin kept", 8'h01, {7'h0, tx_oe_o});
    n = 0;
    while (tx_oe_o !== 1'b0) step(n);
    chk("sent byte", 8'ha5, i_serial_peer.got);
    rd(serial_pkg::A_STAT1);
    chk("complete", 8'h40, d & 8'h40);
    chk("idle after", 8'h01, {7'h0, tx_o});
    wr(serial_pkg::A_CTRL3, 8'h10);
    #1 chk("inverted idle", 8'h00, {7'h0, tx_o});
    wr(serial_pkg::A_CTRL3, 8'h00);
    wr(serial_pkg::A_CTRL2, 8'h0c);
    for (int i = 0; i < 4; i++) begin
      wr(serial_pkg::A_CTRL1, i[0] ? 8'h10 : 8'h00);
      wr(serial_pkg::A_STAT2, i[1] ? 8'h04 : 8'h00);
      // start just after a bit clock so the pulse ends before the next load
      do @(posedge clock_i); while ((($time - t0) / 8) % BITC != 1);
      wr(serial_pkg::A_CTRL2, 8'h0d);
      wr(serial_pkg::A_CTRL2, 8'h0c);
      n = 0;
      while (tx_o !== 1'b0) step(n);
      n = 0;
      while (tx_o === 1'b0) step(n);
      chk("break bits", 8'(blen[i]), 8'(n / BITC));
    end
    wr(serial_pkg::A_CTRL1, 8'h00);
    wr(serial_pkg::A_STAT2, 8'h00);
    i_serial_peer.send(8'h3c, 1'b1);
    rd(serial_pkg::A_STAT1);
    chk("rx full", 8'h20, d & 8'h2e);
    rd(serial_pkg::A_DATA);
    chk("rx data", 8'h3c, d);
    rd(serial_pkg::A_STAT1);
    chk("rx cleared", 8'h00, d & 8'h2e);
    i_serial_peer.send(8'h11, 1'b1);
    i_serial_peer.send(8'h22, 1'b1);
    rd(serial_pkg::A_STAT1);
    chk("overrun", 8'h28, d & 8'h2e);
    rd(serial_pkg::A_DATA);
    chk("first kept", 8'h11, d);
    rd(serial_pkg::A_STAT1);
    chk("flags cleared", 8'h00, d & 8'h2e);
    i_serial_peer.send(8'h5a, 1'b1, 2);
    rd(serial_pkg::A_STAT1);
    chk("noise", 8'h24, d & 8'h2e);
    rd(serial_pkg::A_DATA);
    chk("noisy data", 8'h5a, d);
    i_serial_peer.send(8'h55, 1'b0);
    i_serial_peer.send(8'h66, 1'b1);
    rd(serial_pkg::A_STAT1);
    chk("framing", 8'h22, d & 8'h2e);
    rd(serial_pkg::A_DATA);
    chk("blocked", 8'h55, d);
    rd(serial_pkg::A_STAT1);
    chk("framing cleared", 8'h00, d & 8'h2e);
    print_verdict();
  end
endmodule : async_serial_txrx_core_tb
